// ### common/sef_pkg.sv
// Constants, state types and carriers of the serial memory front end
package sef_pkg;

   // Array geometry
   localparam int unsigned ADDR_W     = 13;
   localparam int unsigned MEM_BYTES  = 8192;
   localparam int unsigned PAGE_BYTES = 64;

   // Opcodes
   localparam logic [7:0] OP_SET_WL  = 8'h06;
   localparam logic [7:0] OP_CLR_WL  = 8'h04;
   localparam logic [7:0] OP_ST_READ = 8'h05;
   localparam logic [7:0] OP_ST_WRIT = 8'h01;
   localparam logic [7:0] OP_READ    = 8'h03;
   localparam logic [7:0] OP_WRITE   = 8'h02;

   // Status register fields
   localparam int unsigned ST_READY   = 0;
   localparam int unsigned ST_WL      = 1;
   localparam int unsigned ST_BG_LOW  = 2;
   localparam int unsigned ST_BG_HIGH = 3;
   localparam int unsigned ST_PIN_EN  = 7;
   localparam logic [7:0]  ST_WR_MASK = 8'h8c;
   localparam logic [7:0]  ST_RESET   = 8'h00;

   // Start of each guarded region
   localparam logic [12:0] QUARTER_BASE = 13'h1800;
   localparam logic [12:0] HALF_BASE    = 13'h1000;

   // Program cycle timing
   localparam int unsigned CORE_CLK_HZ  = 50_000_000;
   localparam int unsigned PROG_TIME_US = 5000;
   localparam int unsigned PROG_CYCLES  = PROG_TIME_US * (CORE_CLK_HZ / 1_000_000);

   // Byte position within a frame
   typedef enum logic [3:0] {
      PH_OPCODE = 4'b0001,
      PH_ADDR_HI = 4'b0010,
      PH_ADDR_LO = 4'b0100,
      PH_DATA   = 4'b1000
   } sef_phase_t;

   // Program cycle sequencer
   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_COPY = 3'b010,
      PS_WAIT = 3'b100
   } sef_prog_t;

   // State of the serial clock side
   typedef struct packed {
      logic [2:0]  bits;
      sef_phase_t  phase;
      logic [7:0]  shift;
      logic [7:0]  opcode;
      logic [7:0]  addr_hi;
      logic [12:0] ptr;
      logic [6:0]  page_base;
      logic [63:0] mask;
      logic [7:0]  tx;
      logic [7:0]  st_data;
      logic        data_seen;
      logic        ftog;
      logic [7:0]  st_s1;
      logic [7:0]  st_s2;
   } sef_link_t;

   // State of the core clock side
   typedef struct packed {
      logic       cs_s1, cs_s2, cs_d;
      logic       wp_s1, wp_s2, wp_d;
      logic       hold_s1, hold_s2;
      logic [7:0] status;
      logic       wr_abort;
      logic       seen_tog;
      sef_prog_t  pst;
      logic [5:0] idx;
      logic [6:0] base;
      logic [17:0] timer;
      logic       so_oe;
   } sef_core_t;

   function automatic sef_link_t link_init();
      link_init       = '0;
      link_init.phase = PH_OPCODE;
   endfunction : link_init

   function automatic sef_core_t core_init();
      core_init        = '0;
      core_init.status = ST_RESET;
      core_init.pst    = PS_IDLE;
   endfunction : core_init

   localparam sef_link_t LINK_INIT = link_init();
   localparam sef_core_t CORE_INIT = core_init();

endpackage : sef_pkg

// ### logic/sef_front_end.sv
// Serial command front end of a byte-wide electrically erasable memory

module sef_front_end #(
   parameter int unsigned PROG_CYCLES = sef_pkg::PROG_CYCLES
) (
   // Core clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic core_ce,
   // Serial link
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic si,
   output logic      so,
   output logic      so_oe,
   // Pause and protect pins
   input  wire logic hold_n,
   input  wire logic wp_n
);

   // Two clock domains share this block
   // Link side runs on the serial clock
   // Core side runs on the core clock
   // Select edges cross through two flops
   // Protect and hold pins cross the same way
   // Frame results cross quasi-statically
   // Frame toggle marks a fresh result
   // Link state is still while deselected
   // Core reads it only after select rises
   // Status crosses back through two serial flops
   // Status is stable for many serial edges
   // Page buffer filled on the link side
   // Page buffer emptied on the core side
   // Host must keep select high long enough

   // Link side state
   sef_pkg::sef_link_t lr;
   sef_pkg::sef_link_t ln;
   logic               fresh;
   logic               frame_clr;
   logic [7:0]         rx_byte;
   logic               page_we;
   logic [5:0]         page_idx;

   // Core side state
   sef_pkg::sef_core_t cr;
   sef_pkg::sef_core_t cn;
   logic               cell_we;

   // Storage
   logic [7:0] cell_mem [sef_pkg::MEM_BYTES];
   logic [7:0] page_mem [sef_pkg::PAGE_BYTES];

   // Guard bits select the protected span
   // Quarter and half start at fixed bases
   // Full guard covers the whole array
   // Page base is checked, page never straddles
   // Region check against the guard setting
   function automatic logic guarded(input logic [12:0] a, input logic [1:0] bg);
      case (bg)
         2'b01: guarded = (a >= sef_pkg::QUARTER_BASE);
         2'b10: guarded = (a >= sef_pkg::HALF_BASE);
         2'b11: guarded = 1'b1;
         default: guarded = 1'b0;
      endcase
   endfunction : guarded

   // Select high holds the flag set
   // First unpaused edge clears it
   // Avoids leftover bits from a cut frame
   // Paused edges leave the flag alone
   // Marks the first serial edge of each frame
   assign frame_clr = reset | cs_n;

   always_ff @(posedge sck or posedge frame_clr) begin
      if (frame_clr) begin
         fresh <= 1'b1;
      end else if (hold_n) begin
         fresh <= 1'b0;
      end
   end

   // Bits counted modulo eight per byte
   // Phase steps opcode, address, data
   // Busy status turns foreign opcodes into zero
   // Read data preloaded one byte ahead
   // Write data goes to the page buffer
   // Mask records which page bytes were sent
   // Only the first status data byte counts
   // Paused edges only move the status crossing
   // Link next state: shift in, decode, stream out
   always_comb begin
      logic [2:0]          cur_bits;
      sef_pkg::sef_phase_t cur_phase;
      logic [7:0]          op_in;
      logic [12:0]         addr_full;
      ln        = lr;
      page_we   = 1'b0;
      page_idx  = lr.ptr[5:0];
      rx_byte   = {lr.shift[6:0], si};
      cur_bits  = fresh ? 3'h0 : lr.bits;
      cur_phase = fresh ? sef_pkg::PH_OPCODE : lr.phase;
      op_in     = rx_byte;
      addr_full = {lr.addr_hi[4:0], rx_byte};
      // Status level crossing from the core side
      ln.st_s1  = cr.status;
      ln.st_s2  = lr.st_s1;
      if (hold_n) begin
         ln.shift = rx_byte;
         ln.bits  = cur_bits + 3'h1;
         ln.tx    = {lr.tx[6:0], 1'b0};
         if (fresh) begin
            ln.ftog      = ~lr.ftog;
            ln.opcode    = 8'h00;
            ln.data_seen = 1'b0;
            ln.phase     = sef_pkg::PH_OPCODE;
         end
         if (cur_bits == 3'h7) begin
            case (cur_phase)
               sef_pkg::PH_OPCODE: begin
                  if (lr.st_s2[sef_pkg::ST_READY] && rx_byte != sef_pkg::OP_ST_READ) begin
                     op_in = 8'h00;
                  end
                  ln.opcode = op_in;
                  case (op_in)
                     sef_pkg::OP_ST_READ: begin
                        ln.tx    = lr.st_s2;
                        ln.phase = sef_pkg::PH_DATA;
                     end
                     sef_pkg::OP_READ, sef_pkg::OP_WRITE: begin
                        ln.phase = sef_pkg::PH_ADDR_HI;
                     end
                     default: begin
                        ln.phase = sef_pkg::PH_DATA;
                     end
                  endcase
               end
               sef_pkg::PH_ADDR_HI: begin
                  ln.addr_hi = rx_byte;
                  ln.phase   = sef_pkg::PH_ADDR_LO;
               end
               sef_pkg::PH_ADDR_LO: begin
                  ln.phase     = sef_pkg::PH_DATA;
                  ln.page_base = addr_full[12:6];
                  ln.mask      = '0;
                  if (lr.opcode == sef_pkg::OP_READ) begin
                     ln.tx  = cell_mem[addr_full];
                     ln.ptr = addr_full + 13'h1;
                  end else begin
                     ln.ptr = addr_full;
                  end
               end
               sef_pkg::PH_DATA: begin
                  ln.data_seen = 1'b1;
                  case (lr.opcode)
                     sef_pkg::OP_READ: begin
                        ln.tx  = cell_mem[lr.ptr];
                        ln.ptr = lr.ptr + 13'h1;
                     end
                     sef_pkg::OP_ST_READ: begin
                        ln.tx = lr.st_s2;
                     end
                     sef_pkg::OP_ST_WRIT: begin
                        if (!lr.data_seen) begin
                           ln.st_data = rx_byte;
                        end
                     end
                     sef_pkg::OP_WRITE: begin
                        page_we                = 1'b1;
                        ln.mask[lr.ptr[5:0]]   = 1'b1;
                        ln.ptr[5:0]            = lr.ptr[5:0] + 6'h1;
                     end
                     default: begin
                     end
                  endcase
               end
               default: begin
                  ln.phase = sef_pkg::PH_OPCODE;
               end
            endcase
         end
      end
   end

   // Link state register
   always_ff @(posedge sck or posedge reset) begin
      if (reset) begin
         lr <= sef_pkg::LINK_INIT;
      end else begin
         lr <= ln;
      end
   end

   // Later bytes overwrite after page wrap
   // Page buffer fill
   always_ff @(posedge sck) begin
      if (page_we) begin
         page_mem[page_idx] <= rx_byte;
      end
   end

   // Host samples on the next rising edge
   // Paused falling edges leave the bit
   // Serial output launch
   always_ff @(negedge sck or posedge reset) begin
      if (reset) begin
         so <= 1'b0;
      end else if (hold_n) begin
         so <= lr.tx[7];
      end
   end

   // Pins pass two flops before any use
   // Select rise ends a frame
   // Select fall starts a fresh abort window
   // Latch and status act only at frame end
   // Incomplete bytes make the frame void
   // Copy phase moves sent bytes to the array
   // Wait phase models the self-timed cycle
   // Ready and latch drop when it ends
   // Core next state: pin sync, deselect decisions, program cycle
   always_comb begin
      logic sel_end;
      logic sel_start;
      logic wp_fall;
      logic hw_lock;
      cn        = cr;
      cell_we   = 1'b0;
      cn.cs_s1  = cs_n;
      cn.cs_s2  = cr.cs_s1;
      cn.cs_d   = cr.cs_s2;
      cn.wp_s1  = wp_n;
      cn.wp_s2  = cr.wp_s1;
      cn.wp_d   = cr.wp_s2;
      cn.hold_s1 = hold_n;
      cn.hold_s2 = cr.hold_s1;
      sel_end   = cr.cs_s2 & ~cr.cs_d;
      sel_start = ~cr.cs_s2 & cr.cs_d;
      wp_fall   = ~cr.wp_s2 & cr.wp_d;
      hw_lock   = cr.status[sef_pkg::ST_PIN_EN] & ~cr.wp_s2;
      // Output enable follows select and hold
      cn.so_oe  = ~cr.cs_s2 & cr.hold_s2;
      // Abort flag: a pin fall beats the frame-start clear
      if (~cr.cs_s2 & wp_fall) begin
         cn.wr_abort = 1'b1;
      end else if (sel_start) begin
         cn.wr_abort = 1'b0;
      end
      // Frame end: link state is still while deselected
      if (sel_end && lr.ftog != cr.seen_tog) begin
         cn.seen_tog = lr.ftog;
         if (cr.pst == sef_pkg::PS_IDLE && lr.bits == 3'h0) begin
            case (lr.opcode)
               sef_pkg::OP_SET_WL: begin
                  cn.status[sef_pkg::ST_WL] = 1'b1;
               end
               sef_pkg::OP_CLR_WL: begin
                  cn.status[sef_pkg::ST_WL] = 1'b0;
               end
               sef_pkg::OP_ST_WRIT: begin
                  if (lr.data_seen && cr.status[sef_pkg::ST_WL] && !hw_lock
                      && !(cr.wr_abort
                           && cr.status[sef_pkg::ST_PIN_EN])) begin
                     cn.status = (cr.status & ~sef_pkg::ST_WR_MASK)
                               | (lr.st_data & sef_pkg::ST_WR_MASK);
                     cn.status[sef_pkg::ST_READY] = 1'b1;
                     cn.timer = 18'h0;
                     cn.pst   = sef_pkg::PS_WAIT;
                  end
               end
               sef_pkg::OP_WRITE: begin
                  if (lr.data_seen && cr.status[sef_pkg::ST_WL]
                      && !guarded({lr.page_base, 6'h00},
                                  cr.status[sef_pkg::ST_BG_HIGH:sef_pkg::ST_BG_LOW]))
                  begin
                     cn.status[sef_pkg::ST_READY] = 1'b1;
                     cn.idx  = 6'h00;
                     cn.base = lr.page_base;
                     cn.pst  = sef_pkg::PS_COPY;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Program cycle runs regardless of select
      case (cr.pst)
         sef_pkg::PS_IDLE: begin
         end
         sef_pkg::PS_COPY: begin
            cell_we = lr.mask[cr.idx];
            cn.idx  = cr.idx + 6'h1;
            if (cr.idx == 6'h3f) begin
               cn.timer = 18'h0;
               cn.pst   = sef_pkg::PS_WAIT;
            end
         end
         sef_pkg::PS_WAIT: begin
            cn.timer = cr.timer + 18'h1;
            if (cr.timer == 18'(PROG_CYCLES - 1)) begin
               cn.status[sef_pkg::ST_READY] = 1'b0;
               cn.status[sef_pkg::ST_WL]    = 1'b0;
               cn.pst                       = sef_pkg::PS_IDLE;
            end
         end
         default: begin
            cn.pst = sef_pkg::PS_IDLE;
         end
      endcase
   end

   // Enable low holds every core flop
   // Link side keeps running meanwhile
   // Core state register, frozen while the enable is low
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cr <= sef_pkg::CORE_INIT;
      end else if (core_ce) begin
         cr <= cn;
      end
   end

   // Only bytes marked in the mask land
   // Unsent page bytes keep old contents
   // Array programming from the page buffer
   always_ff @(posedge core_clk) begin
      if (core_ce && cell_we) begin
         cell_mem[{cr.base, cr.idx}] <= page_mem[cr.idx];
      end
   end

   // Output enable straight from a core flop
   // Lags the pins by three core cycles
   assign so_oe = cr.so_oe;

endmodule : sef_front_end

// ### test/sef_front_end_asserts.sv
// Port checker of the serial memory front end
module sef_front_end_asserts #(
   parameter int unsigned PROG_CYCLES = 200
) (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic reset,
   input wire logic core_ce,
   // Serial link and pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic hold_n,
   input wire logic wp_n
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // Output enable follows select and pause
   a_desel_float: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
      else $error("output still driven after deselect");
   a_idle_float: assert property (cs_n [*6] |-> !so_oe)
      else $error("output driven while deselected");
   a_oe_cause: assert property ($rose(so_oe) |-> !cs_n && hold_n)
      else $error("output enabled without select");
   a_hold_float: assert property ((!hold_n) [*5] |-> !so_oe)
      else $error("output driven while paused");
   a_resume_drive: assert property ($rose(hold_n) && !cs_n |-> ##[2:6] so_oe)
      else $error("output not driven after resume");
   // Data line moves only on a falling serial clock
   a_so_on_fall: assert property (sck && $past(sck) |-> $stable(so))
      else $error("data out moved while serial clock high");
   a_hold_freeze: assert property (!hold_n && $past(!hold_n) |-> $stable(so))
      else $error("data out moved while paused");
   a_desel_quiet: assert property (cs_n && $past(cs_n) |-> $stable(so))
      else $error("data out moved while deselected");

   // Main scenarios
   c_frame: cover property ($fell(cs_n));
   c_pause: cover property ($fell(hold_n) && !cs_n);
   c_data: cover property ($rose(so) && so_oe);
endmodule : sef_front_end_asserts

bind sef_front_end sef_front_end_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
   .core_clk(core_clk), .reset(reset), .core_ce(core_ce), .sck(sck), .cs_n(cs_n),
   .si(si), .so(so), .so_oe(so_oe), .hold_n(hold_n), .wp_n(wp_n));

// ### test/sef_front_end_tb.sv
// Self-checking bench of the serial memory front end
module sef_front_end_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic       core_clk, reset, core_ce, wp_n, sck, cs_n, si, so, so_oe, hold_n;
   int         error_cnt, cmp_count;
   logic [7:0] st;
   logic [7:0] mem [int];
   logic [7:0] r [$];
   logic [7:0] s;

   // Core clock
   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;

   sef_front_end #(.PROG_CYCLES(200)) u_dut (.core_clk(core_clk), .reset(reset),
      .core_ce(core_ce), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
      .hold_n(hold_n), .wp_n(wp_n));
   sef_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
      .so_oe(so_oe));

   // Verdict and end of run
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done

   // Byte compare
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic send(input logic [7:0] tx[$]);
      u_host.frame(tx, 0, -1, 0, r);
   endtask : send

   task automatic rdst(output logic [7:0] v);
      u_host.frame({sef_pkg::OP_ST_READ}, 1, -1, 0, r);
      v = r[0];
   endtask : rdst

   task automatic pin(input logic v);
      @(negedge core_clk);
      wp_n <= v;
   endtask : pin

   // Poll until the program cycle ends
   task automatic wait_ready();
      int k;
      for (k = 0; k < 100; k++) begin
         rdst(s);
         if (s[0] === 1'b0) break;
      end
      if (k == 100) begin
         error_cnt++;
         test_done();
      end
   endtask : wait_ready

   // Latch, write, busy check if ok, wait, status check, clear latch
   task automatic wop(input logic [7:0] tx[$], input bit ok, input bit wpf);
      send({sef_pkg::OP_SET_WL});
      fork
         send(tx);
         if (wpf && !ok) begin
            repeat (40) @(negedge core_clk);
            wp_n <= 1'b0;
            repeat (5) @(negedge core_clk);
            wp_n <= 1'b1;
         end
      join
      if (wpf && ok) pin(1'b0);
      if (ok) begin
         send({sef_pkg::OP_CLR_WL});
         rdst(s);
         chk({6'h00, s[1:0]}, 8'h03);
      end
      wait_ready();
      rdst(s);
      chk(s, ok ? st : (st | 8'h02));
      send({sef_pkg::OP_CLR_WL});
      rdst(s);
      chk(s, st);
   endtask : wop

   // Array write of n random bytes, model wraps in page
   task automatic mwr(input logic [15:0] a, input int n, input bit ok);
      logic [7:0] tx[$];
      logic [7:0] d;
      tx = {sef_pkg::OP_WRITE, a[15:8], a[7:0]};
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         tx.push_back(d);
         if (ok) mem[{a[12:6], 6'(a[5:0] + i)}] = d;
      end
      wop(tx, ok, 1'b0);
   endtask : mwr

   // Array read of n bytes with optional pause
   task automatic mrd(input logic [15:0] a, input int n, input int h);
      u_host.frame({sef_pkg::OP_READ, a[15:8], a[7:0]}, n, h, 0, r);
      for (int i = 0; i < n; i++) chk(r[i], mem[(a[12:0] + i) % 8192]);
   endtask : mrd

   // Hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      error_cnt++;
      test_done();
   end

   // Main sequence
   initial begin
      error_cnt = 0;
      cmp_count = 0;
      st = 8'h00;
      reset = 1'b1;
      core_ce = 1'b1;
      wp_n = 1'b1;
      void'($urandom(60));
      repeat (5) @(negedge core_clk);
      reset <= 1'b0;
      repeat (5) @(negedge core_clk);
      rdst(s);
      chk(s, 8'h00);
      u_host.frame({sef_pkg::OP_SET_WL}, 0, -1, 5, r);
      rdst(s);
      chk(s, 8'h00);
      $display("test reset and abort done");
      mwr(16'h1ffe, 4, 1'b1);
      mwr(16'h0000, 2, 1'b1);
      send({sef_pkg::OP_WRITE, 8'h00, 8'h00, 8'h5a});
      rdst(s);
      chk(s, 8'h00);
      mrd(16'hfffe, 4, 20);
      mrd(16'h1fc0, 2, -1);
      $display("test array write and read done");
      st = 8'h8c;
      wop({sef_pkg::OP_ST_WRIT, 8'h8f}, 1'b1, 1'b0);
      mwr(16'h0000, 1, 1'b0);
      pin(1'b0);
      wop({sef_pkg::OP_ST_WRIT, 8'h00}, 1'b0, 1'b0);
      pin(1'b1);
      st = 8'h84;
      wop({sef_pkg::OP_ST_WRIT, 8'h84}, 1'b1, 1'b0);
      pin(1'b0);
      mwr(16'h0002, 1, 1'b1);
      mwr(16'h1800, 1, 1'b0);
      pin(1'b1);
      $display("test guard and lock done");
      wop({sef_pkg::OP_ST_WRIT, 8'h00}, 1'b0, 1'b1);
      pin(1'b1);
      st = 8'h00;
      wop({sef_pkg::OP_ST_WRIT, 8'h00}, 1'b1, 1'b1);
      st = 8'h08;
      wop({sef_pkg::OP_ST_WRIT, 8'h08}, 1'b1, 1'b0);
      pin(1'b1);
      mrd(16'h0000, 3, -1);
      $display("test protect pin done");
      test_done();
   end
endmodule : sef_front_end_tb

// ### test/sef_host_model.sv
// Host controller model driving the serial link of the front end
module sef_host_model (
   // Serial link
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n,
   input  wire logic so,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   // Link idles with clock low and no pause
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
   end

   // Pause with clock low, keep toggling clock and data while paused
   task automatic pause();
      logic keep;
      keep = si;
      hold_n = 1'b0;
      repeat (3) begin
         #32 sck = 1'b1;
         #32 sck = 1'b0;
         si = ~si;
      end
      si = keep;
      hold_n = 1'b1;
   endtask : pause

   // One select cycle: send bytes, take nrx bytes, optional pause or early cut
   task automatic frame(input logic [7:0] tx[$], input int nrx, input int hold_at,
                        input int cut, output logic [7:0] rx[$]);
      int         nb;
      logic [7:0] b;
      nb = (cut > 0) ? cut : 8 * (tx.size() + nrx);
      rx = {};
      b = 8'h00;
      cs_n = 1'b0;
      #100;
      for (int i = 0; i < nb; i++) begin
         si = (i < 8 * tx.size()) ? tx[i / 8][7 - i % 8] : 1'($urandom_range(1));
         if (i == hold_at) pause();
         #32 b = {b[6:0], so};
         sck = 1'b1;
         if (i % 8 == 7 && i >= 8 * tx.size()) rx.push_back(b);
         #32 sck = 1'b0;
      end
      #100 cs_n = 1'b1;
      si = ~si;
      #300;
   endtask : frame
endmodule : sef_host_model
